// ===== logic/rsfs_top.sv
// Run command and frequency reference source selection
`timescale 1ns/1ps
`default_nettype none
module rsfs_top #(
   parameter int unsigned CONFLICT_CYC = rsfs_pkg::CONFLICT_CYC,
   parameter int unsigned HOLD_CYC = rsfs_pkg::HOLD_CYC,
   parameter logic [7:0] FN_UP = 8'h20,
   parameter logic [7:0] FN_DOWN = 8'h21,
   parameter int unsigned UPDN_RATE_CYC = 100
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [5:0] term_in,
   input wire logic [5:0][7:0] term_fn,
   input wire logic [3:0] init_sel,
   input wire logic init_wr,
   input wire logic [2:0] run_src_main,
   input wire logic [2:0] run_src_alt,
   input wire rsfs_pkg::rsfs_key_t key_cmd,
   input wire rsfs_pkg::rsfs_cmd_t ser_cmd,
   input wire rsfs_pkg::rsfs_cmd_t plc_cmd,
   input wire rsfs_pkg::rsfs_cmd_t rtc_cmd,
   input wire logic [2:0] freq_src_main,
   input wire logic [2:0] freq_src_alt,
   input wire logic freq_alt_sel,
   input wire logic [3:0] analog_func,
   input wire logic ai2_type,
   input wire logic [15:0] ai1_val,
   input wire logic [15:0] ai2_val,
   input wire logic [15:0] key_freq,
   input wire logic [15:0] stage0_freq,
   input wire logic [15:0] comm_freq,
   input wire logic [15:0] rtc_freq,
   output rsfs_pkg::rsfs_cmd_t cmd_q,
   output logic alt_run_q,
   output logic direction_conflict_alarm_q,
   output logic terminal_config_conflict_error_q,
   output logic ai2_current_q,
   output logic [15:0] freq_ref_q
);
   localparam int unsigned KW = $clog2(CONFLICT_CYC + 1);
   localparam logic [KW-1:0] KLAST = KW'(CONFLICT_CYC - 1);

   function automatic logic fn_any(input logic [5:0][7:0] fn,
         input logic [7:0] code, input int lo, input int hi);
      logic hit;
      hit = 1'b0;
      for (int i = lo; i <= hi; i++) begin
         hit = hit | (fn[i] == code);
      end
      return hit;
   endfunction

   function automatic logic fn_on(input logic [5:0][7:0] fn,
         input logic [7:0] code, input logic [5:0] lv);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 6; i++) begin
         hit = hit | ((fn[i] == code) & lv[i]);
      end
      return hit;
   endfunction

   function automatic logic [15:0] ai2_scale(input logic [15:0] raw,
         input logic cur);
      logic [17:0] t;
      t = 18'h0_0000;
      if (cur != rsfs_pkg::AI2_TYPE_CURRENT) begin
         return raw;
      end
      if (raw < rsfs_pkg::AI_LIVE_ZERO) begin
         return 16'h0000;
      end
      t = {2'b00, raw - rsfs_pkg::AI_LIVE_ZERO} * 18'h0_0005;
      return t[17:2];
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] a,
         input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[16] ? 16'hFFFF : s[15:0];
   endfunction

   logic [5:0] lvl, held;
   logic [15:0] updn_val;

   for (genvar g = 0; g < 6; g++) begin : g_term
      rsfs_hold #(.HOLD_CYC(HOLD_CYC)) u_hold (
         .clk(clk),
         .arst_n(arst_n),
         .pin(term_in[g]),
         .level(lvl[g]),
         .held(held[g])
      );
   end

   // Terminal mode decode
   rsfs_pkg::rsfs_preset_t preset_q, preset_d;
   rsfs_pkg::rsfs_tmode_t mode;
   logic three_en, latch_en, two_en, cfg_err;

   always_comb begin
      preset_d = preset_q;
      if (init_wr) begin
         if (init_sel == 4'h2 || init_sel == 4'h4 || init_sel == 4'h6) begin
            preset_d = rsfs_pkg::PR_TWO;
         end else if (init_sel == 4'h3 || init_sel == 4'h5
               || init_sel == 4'h7) begin
            preset_d = rsfs_pkg::PR_THREE;
         end else begin
            preset_d = rsfs_pkg::PR_NONE;
         end
      end
      three_en = fn_any(term_fn, rsfs_pkg::FN_THREE_WIRE, 2, 5)
         || preset_q == rsfs_pkg::PR_THREE;
      latch_en = fn_any(term_fn, rsfs_pkg::FN_LATCH, 0, 5);
      two_en = (term_fn[0] == rsfs_pkg::FN_FWD_RUN
         && term_fn[1] == rsfs_pkg::FN_REV_RUN)
         || preset_q == rsfs_pkg::PR_TWO;
      cfg_err = three_en && latch_en;
      if (cfg_err) begin
         mode = rsfs_pkg::TM_NONE;
      end else if (latch_en) begin
         mode = rsfs_pkg::TM_LATCH;
      end else if (three_en) begin
         mode = rsfs_pkg::TM_THREE;
      end else if (two_en) begin
         mode = rsfs_pkg::TM_TWO;
      end else begin
         mode = rsfs_pkg::TM_NONE;
      end
   end

   // Terminal command decode
   rsfs_pkg::rsfs_cmd_t term_q, term_d;
   rsfs_pkg::rsfs_lstate_t ls_q, ls_d;
   logic [KW-1:0] conf_q, conf_d;
   logic alarm_d, both;

   always_comb begin
      term_d = term_q;
      ls_d = rsfs_pkg::LS_STOP;
      both = lvl[0] && lvl[1];
      conf_d = '0;
      alarm_d = 1'b0;
      case (mode)
         rsfs_pkg::TM_TWO: begin
            term_d.run = lvl[0] ^ lvl[1];
            if (lvl[0] && !lvl[1]) begin
               term_d.fwd = 1'b1;
            end else if (lvl[1] && !lvl[0]) begin
               term_d.fwd = 1'b0;
            end
            if (both) begin
               conf_d = (conf_q == KLAST) ? conf_q : conf_q + KW'(1);
               alarm_d = (conf_q == KLAST);
            end
         end
         rsfs_pkg::TM_THREE: begin
            if (!lvl[1]) begin
               term_d.run = 1'b0;
            end else if (held[0]) begin
               term_d.run = 1'b1;
            end
            term_d.fwd = !lvl[4];
         end
         rsfs_pkg::TM_LATCH: begin
            ls_d = ls_q;
            case (ls_q)
               rsfs_pkg::LS_STOP: begin
                  if (held[0]) begin
                     ls_d = rsfs_pkg::LS_FWD;
                  end else if (held[1]) begin
                     ls_d = rsfs_pkg::LS_REV;
                  end
               end
               rsfs_pkg::LS_FWD: begin
                  if (held[4]) begin
                     ls_d = rsfs_pkg::LS_STOP;
                  end else if (held[1]) begin
                     ls_d = rsfs_pkg::LS_REV;
                  end
               end
               rsfs_pkg::LS_REV: begin
                  if (held[4]) begin
                     ls_d = rsfs_pkg::LS_STOP;
                  end else if (held[0]) begin
                     ls_d = rsfs_pkg::LS_FWD;
                  end
               end
               default: ls_d = rsfs_pkg::LS_STOP;
            endcase
            term_d.run = (ls_d != rsfs_pkg::LS_STOP);
            term_d.fwd = (ls_d != rsfs_pkg::LS_REV);
         end
         default: term_d.run = 1'b0;
      endcase
   end

   // Keypad state and run source selection
   rsfs_pkg::rsfs_cmd_t kp_q, kp_d, cmd_d;
   logic alt_d;
   logic [2:0] rsrc;

   always_comb begin
      kp_d = kp_q;
      if (key_cmd.stop) begin
         kp_d.run = 1'b0;
      end else if (key_cmd.run) begin
         kp_d.run = 1'b1;
      end
      if (key_cmd.dir_toggle) begin
         kp_d.fwd = !kp_q.fwd;
      end
      alt_d = fn_on(term_fn, rsfs_pkg::FN_RUN_SWITCH, lvl);
      rsrc = alt_d ? run_src_alt : run_src_main;
      cmd_d = '{run: 1'b0, fwd: 1'b1};
      case (rsrc)
         rsfs_pkg::RSRC_KEYPAD: cmd_d = kp_d;
         rsfs_pkg::RSRC_TERM: cmd_d = term_d;
         rsfs_pkg::RSRC_SERIAL: cmd_d = ser_cmd;
         rsfs_pkg::RSRC_PLC: cmd_d = plc_cmd;
         rsfs_pkg::RSRC_RTC: cmd_d = rtc_cmd;
         default: cmd_d = '{run: 1'b0, fwd: 1'b1};
      endcase
   end

   // Frequency reference selection
   logic [2:0] fsrc;
   logic [15:0] ai2s, ana, freq_d;
   logic updn_en;

   always_comb begin
      ai2s = ai2_scale(ai2_val, ai2_type);
      case (analog_func)
         rsfs_pkg::AFUNC_SWITCH: begin
            ana = fn_on(term_fn, rsfs_pkg::FN_AI_SWITCH, lvl)
               ? ai2s : ai1_val;
         end
         rsfs_pkg::AFUNC_DIRECT: begin
            ana = (ai2_type == rsfs_pkg::AI2_TYPE_CURRENT)
               ? ai2s : ai1_val;
         end
         rsfs_pkg::AFUNC_SUM: ana = sat_add(ai1_val, ai2s);
         default: ana = ai1_val;
      endcase
      fsrc = freq_alt_sel ? freq_src_alt : freq_src_main;
      updn_en = (fsrc == rsfs_pkg::FSRC_UPDN)
         && fn_any(term_fn, FN_UP, 0, 5)
         && fn_any(term_fn, FN_DOWN, 0, 5);
      case (fsrc)
         rsfs_pkg::FSRC_KEYPAD: begin
            freq_d = freq_alt_sel ? stage0_freq : key_freq;
         end
         rsfs_pkg::FSRC_AI1: freq_d = ana;
         rsfs_pkg::FSRC_UPDN: freq_d = updn_val;
         rsfs_pkg::FSRC_COMM: freq_d = comm_freq;
         rsfs_pkg::FSRC_RTC: freq_d = rtc_freq;
         rsfs_pkg::FSRC_AI2: freq_d = ai2s;
         default: freq_d = 16'h0000;
      endcase
   end

   rsfs_updown #(.W(16), .RATE_CYC(UPDN_RATE_CYC)) u_updn (
      .clk(clk),
      .arst_n(arst_n),
      .en(updn_en),
      .up(fn_on(term_fn, FN_UP, lvl)),
      .down(fn_on(term_fn, FN_DOWN, lvl)),
      .val(updn_val)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         preset_q <= rsfs_pkg::PR_NONE;
         term_q <= '{run: 1'b0, fwd: 1'b1};
         ls_q <= rsfs_pkg::LS_STOP;
         conf_q <= '0;
         kp_q <= '{run: 1'b0, fwd: 1'b1};
         cmd_q <= '{run: 1'b0, fwd: 1'b1};
         alt_run_q <= 1'b0;
         direction_conflict_alarm_q <= 1'b0;
         terminal_config_conflict_error_q <= 1'b0;
         ai2_current_q <= 1'b0;
         freq_ref_q <= 16'h0000;
      end else begin
         preset_q <= preset_d;
         term_q <= term_d;
         ls_q <= ls_d;
         conf_q <= conf_d;
         kp_q <= kp_d;
         cmd_q <= cmd_d;
         alt_run_q <= alt_d;
         direction_conflict_alarm_q <= alarm_d;
         terminal_config_conflict_error_q <= cfg_err;
         ai2_current_q <= ai2_type;
         freq_ref_q <= freq_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence two_both_s;
      mode == rsfs_pkg::TM_TWO && both;
   endsequence

   cfg_error_a: assert property (cfg_err |=> terminal_config_conflict_error_q)
      else $error("config conflict not flagged");
   alarm_cause_a: assert property ($rose(direction_conflict_alarm_q)
      |-> $past(lvl[0] && lvl[1]))
      else $error("alarm without both terminals closed");
   alarm_clear_a: assert property (!both |=> !direction_conflict_alarm_q)
      else $error("alarm kept after conflict removed");
   two_stop_a: assert property (two_both_s |=> !term_q.run)
      else $error("two-wire both closed must stop");
   two_fwd_a: assert property (mode == rsfs_pkg::TM_TWO && lvl == 6'h01
      |=> term_q.run && term_q.fwd)
      else $error("two-wire forward not taken");
   three_start_a: assert property ($rose(term_q.run)
      && $past(mode) == rsfs_pkg::TM_THREE |-> $past(held[0]))
      else $error("three-wire start before hold time");
   latch_start_a: assert property (ls_q == rsfs_pkg::LS_STOP
      && ls_d == rsfs_pkg::LS_FWD |-> held[0])
      else $error("latched forward without held terminal");
   serial_alt_a: assert property (alt_d && run_src_alt == rsfs_pkg::RSRC_SERIAL
      |=> cmd_q == $past(ser_cmd))
      else $error("alternative serial source not used");
   freq_sum_a: assert property (fsrc == rsfs_pkg::FSRC_AI1
      && analog_func == rsfs_pkg::AFUNC_SUM
      |=> freq_ref_q >= $past(ai1_val))
      else $error("analog sum below first input");
endmodule // rsfs_top
`default_nettype wire

// ===== include/rsfs_pkg.sv
// Constants and types for run and frequency source selection
package rsfs_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CONFLICT_MS = 500;
   localparam int unsigned HOLD_MS = 50;
   localparam int unsigned CONFLICT_CYC = CONFLICT_MS * (CLK_HZ / 1000);
   localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned NUM_TERM = 6;

   // Run command sources
   localparam logic [2:0] RSRC_KEYPAD = 3'h0;
   localparam logic [2:0] RSRC_TERM = 3'h1;
   localparam logic [2:0] RSRC_SERIAL = 3'h2;
   localparam logic [2:0] RSRC_PLC = 3'h3;
   localparam logic [2:0] RSRC_RTC = 3'h4;

   // Frequency sources, 4 and 5 unused
   localparam logic [2:0] FSRC_KEYPAD = 3'h0;
   localparam logic [2:0] FSRC_AI1 = 3'h1;
   localparam logic [2:0] FSRC_UPDN = 3'h2;
   localparam logic [2:0] FSRC_COMM = 3'h3;
   localparam logic [2:0] FSRC_RTC = 3'h6;
   localparam logic [2:0] FSRC_AI2 = 3'h7;

   // Terminal function codes
   localparam logic [7:0] FN_FWD_RUN = 8'h00;
   localparam logic [7:0] FN_REV_RUN = 8'h01;
   localparam logic [7:0] FN_RUN_SWITCH = 8'h0C;
   localparam logic [7:0] FN_AI_SWITCH = 8'h0D;
   localparam logic [7:0] FN_THREE_WIRE = 8'h1A;
   localparam logic [7:0] FN_LATCH = 8'h35;

   // Analog function selector
   localparam logic [3:0] AFUNC_SWITCH = 4'h0;
   localparam logic [3:0] AFUNC_DIRECT = 4'h1;
   localparam logic [3:0] AFUNC_SUM = 4'hA;

   localparam logic AI2_TYPE_CURRENT = 1'b1;
   // 20 % of full scale, the 4 mA live zero
   localparam logic [15:0] AI_LIVE_ZERO = 16'h3333;

   typedef struct packed {
      logic run;
      logic fwd;
   } rsfs_cmd_t;

   typedef struct packed {
      logic run;
      logic stop;
      logic dir_toggle;
   } rsfs_key_t;

   typedef enum logic [3:0] {
      TM_NONE = 4'b0001,
      TM_TWO = 4'b0010,
      TM_THREE = 4'b0100,
      TM_LATCH = 4'b1000
   } rsfs_tmode_t;

   typedef enum logic [2:0] {
      LS_STOP = 3'b001,
      LS_FWD = 3'b010,
      LS_REV = 3'b100
   } rsfs_lstate_t;

   typedef enum logic [2:0] {
      PR_NONE = 3'b001,
      PR_TWO = 3'b010,
      PR_THREE = 3'b100
   } rsfs_preset_t;
endpackage

// ===== logic/rsfs_hold.sv
// Terminal synchroniser with closed-time qualifier
`timescale 1ns/1ps
`default_nettype none
module rsfs_hold #(
   parameter int unsigned HOLD_CYC = rsfs_pkg::HOLD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pin,
   output logic level,
   output logic held
);
   localparam int unsigned CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);
   logic sync1_q, sync2_q, held_q, held_d;
   logic [CW-1:0] cnt_q, cnt_d;

   always_comb begin
      cnt_d = '0;
      if (sync2_q && cnt_q != LAST) begin
         cnt_d = cnt_q + CW'(1);
      end else if (sync2_q) begin
         cnt_d = cnt_q;
      end
      held_d = sync2_q && (cnt_q == LAST);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         cnt_q <= '0;
         held_q <= 1'b0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         cnt_q <= cnt_d;
         held_q <= held_d;
      end
   end

   assign level = sync2_q;
   assign held = held_q;

   held_level_a: assert property (@(posedge clk) disable iff (!arst_n)
      held_q |-> $past(sync2_q))
      else $error("held set without closed level");
endmodule // rsfs_hold
`default_nettype wire

// ===== logic/rsfs_updown.sv
// Up/down frequency accumulator
`timescale 1ns/1ps
`default_nettype none
module rsfs_updown #(
   parameter int unsigned W = rsfs_pkg::FREQ_W,
   parameter int unsigned RATE_CYC = 100
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic en,
   input wire logic up,
   input wire logic down,
   output logic [W-1:0] val
);
   localparam int unsigned PW = $clog2(RATE_CYC + 1);
   logic [PW-1:0] pre_q, pre_d;
   logic [W-1:0] val_q, val_d;

   always_comb begin
      pre_d = (pre_q == PW'(RATE_CYC - 1)) ? '0 : pre_q + PW'(1);
      val_d = val_q;
      if (en && pre_q == '0) begin
         if (up && !down && val_q != '1) begin
            val_d = val_q + W'(1);
         end else if (down && !up && val_q != '0) begin
            val_d = val_q - W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= '0;
         val_q <= '0;
      end else begin
         pre_q <= pre_d;
         val_q <= val_d;
      end
   end

   assign val = val_q;
endmodule // rsfs_updown
`default_nettype wire

// ===== testbench/rsfs_contacts.sv
// Operator contact model on the multi-function input terminals
`timescale 1ns/1ps
`default_nettype none
module rsfs_contacts (
   input wire logic clk,
   output logic [5:0] term_in
);
   initial term_in = 6'h00;
   // New contact pattern at a falling edge, held n cycles
   task automatic set(input logic [5:0] v, input int n);
      @(negedge clk);
      term_in = v;
      repeat (n) @(negedge clk);
   endtask
   // Close the masked contacts for n cycles, then reopen them
   task automatic pulse(input logic [5:0] m, input int n);
      set(term_in | m, n);
      term_in = term_in & ~m;
   endtask
endmodule // rsfs_contacts
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for run and frequency source selection
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g))
module tb;
   typedef struct packed {
      logic [2:0] rs;
      logic [2:0] fs;
      logic [1:0] cmd;
      logic cf;
      logic [15:0] fr;
   } rsfs_row_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] term_in;
   logic [5:0][7:0] term_fn = {8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h00};
   logic [3:0] init_sel = 4'h0;
   logic init_wr = 1'b0;
   logic [2:0] run_src_main = 3'h1;
   logic [2:0] run_src_alt = 3'h2;
   rsfs_pkg::rsfs_key_t key_cmd = '0;
   rsfs_pkg::rsfs_cmd_t ser_cmd = 2'b10;
   rsfs_pkg::rsfs_cmd_t plc_cmd = 2'b11;
   rsfs_pkg::rsfs_cmd_t rtc_cmd = 2'b01;
   logic [2:0] freq_src_main = 3'h0;
   logic [2:0] freq_src_alt = 3'h0;
   logic freq_alt_sel = 1'b0;
   logic [3:0] analog_func = 4'h0;
   logic ai2_type = 1'b0;
   logic [15:0] ai1_val = 16'h2222;
   logic [15:0] ai2_val = 16'h0444;
   logic [15:0] key_freq = 16'h1111;
   logic [15:0] stage0_freq = 16'h6666;
   logic [15:0] comm_freq = 16'h4444;
   logic [15:0] rtc_freq = 16'h5555;
   rsfs_pkg::rsfs_cmd_t cmd_q;
   logic alt_run_q, dconf_q, tconf_q, ai2_current_q;
   logic [15:0] freq_ref_q;
   int tests_run = 0;
   int bad_count = 0;
   rsfs_row_t rows[7] = '{
      {3'h2, 3'h0, 2'b10, 1'b1, 16'h1111},
      {3'h3, 3'h1, 2'b11, 1'b1, 16'h2222},
      {3'h4, 3'h3, 2'b01, 1'b1, 16'h4444},
      {3'h5, 3'h6, 2'b00, 1'b0, 16'h5555},
      {3'h7, 3'h7, 2'b00, 1'b0, 16'h0444},
      {3'h2, 3'h4, 2'b10, 1'b1, 16'h0000},
      {3'h3, 3'h5, 2'b11, 1'b1, 16'h0000}};

   always #50 clk = ~clk;

   rsfs_contacts c (.clk(clk), .term_in(term_in));

   rsfs_top #(.CONFLICT_CYC(20), .HOLD_CYC(5)) uut (
      .clk(clk), .arst_n(arst_n), .term_in(term_in), .term_fn(term_fn),
      .init_sel(init_sel), .init_wr(init_wr), .run_src_main(run_src_main),
      .run_src_alt(run_src_alt), .key_cmd(key_cmd), .ser_cmd(ser_cmd),
      .plc_cmd(plc_cmd), .rtc_cmd(rtc_cmd), .freq_src_main(freq_src_main),
      .freq_src_alt(freq_src_alt), .freq_alt_sel(freq_alt_sel),
      .analog_func(analog_func), .ai2_type(ai2_type), .ai1_val(ai1_val),
      .ai2_val(ai2_val), .key_freq(key_freq), .stage0_freq(stage0_freq),
      .comm_freq(comm_freq), .rtc_freq(rtc_freq), .cmd_q(cmd_q),
      .alt_run_q(alt_run_q), .direction_conflict_alarm_q(dconf_q),
      .terminal_config_conflict_error_q(tconf_q),
      .ai2_current_q(ai2_current_q), .freq_ref_q(freq_ref_q));

   task automatic check(input string nm, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic key(input rsfs_pkg::rsfs_key_t k);
      key_cmd = k;
      step(1);
      key_cmd = '0;
      step(2);
   endtask

   task automatic end_sim;
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim;
   end

   initial begin
      step(10);
      `CHK("rst_cmd", 2'b01, cmd_q);
      `CHK("rst_flags", 4'h0, {alt_run_q, dconf_q, tconf_q, ai2_current_q});
      `CHK("rst_freq", 16'h0000, freq_ref_q);
      arst_n = 1'b1;
      $display("Test reset done");
      foreach (rows[i]) begin
         run_src_main = rows[i].rs;
         freq_src_main = rows[i].fs;
         step(3);
         `CHK("row_run", rows[i].cmd[1], cmd_q.run);
         if (rows[i].cf) `CHK("row_fwd", rows[i].cmd[0], cmd_q.fwd);
         `CHK("row_freq", rows[i].fr, freq_ref_q);
      end
      $display("Test table done");
      run_src_main = 3'h0;
      c.set(6'h01, 6);
      `CHK("key_term", 1'b0, cmd_q.run);
      key(3'b100);
      `CHK("key_run", 2'b11, cmd_q);
      key(3'b001);
      `CHK("key_dir", 2'b10, cmd_q);
      key(3'b010);
      `CHK("key_stop", 1'b0, cmd_q.run);
      run_src_main = 3'h1;
      c.set(6'h01, 6);
      `CHK("two_fwd", 2'b11, cmd_q);
      c.set(6'h02, 6);
      `CHK("two_rev", 2'b10, cmd_q);
      c.set(6'h03, 10);
      `CHK("two_both", 2'b0, {cmd_q.run, dconf_q});
      step(20);
      `CHK("two_alarm", 1'b1, dconf_q);
      c.set(6'h00, 5);
      `CHK("two_clear", 2'b0, {cmd_q.run, dconf_q});
      $display("Test keypad and two-wire done");
      term_fn[5] = 8'h0C;
      c.set(6'h20, 8);
      `CHK("alt_sel", 3'b110, {alt_run_q, cmd_q});
      c.set(6'h00, 8);
      `CHK("alt_off", 1'b0, alt_run_q);
      term_fn[5] = 8'h05;
      term_fn[2] = 8'h1A;
      c.set(6'h02, 6);
      c.pulse(6'h01, 3);
      step(6);
      `CHK("three_short", 1'b0, cmd_q.run);
      c.pulse(6'h01, 10);
      step(6);
      `CHK("three_run", 2'b11, cmd_q);
      c.set(6'h00, 6);
      `CHK("three_stop", 1'b0, cmd_q.run);
      term_fn[3] = 8'h35;
      step(3);
      `CHK("cfg_err", 1'b1, tconf_q);
      c.set(6'h01, 10);
      `CHK("cfg_norun", 1'b0, cmd_q.run);
      c.set(6'h00, 1);
      term_fn[2] = 8'h05;
      step(3);
      `CHK("cfg_clear", 1'b0, tconf_q);
      c.pulse(6'h01, 10);
      step(6);
      `CHK("latch_fwd", 2'b11, cmd_q);
      c.pulse(6'h10, 10);
      step(6);
      `CHK("latch_stop", 1'b0, cmd_q.run);
      c.pulse(6'h02, 10);
      step(6);
      `CHK("latch_rev", 2'b10, cmd_q);
      c.pulse(6'h10, 10);
      term_fn = {8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05};
      init_sel = 4'h2;
      init_wr = 1'b1;
      step(1);
      init_wr = 1'b0;
      c.set(6'h01, 8);
      `CHK("preset_two", 2'b11, cmd_q);
      c.set(6'h00, 6);
      $display("Test terminal modes done");
      freq_src_main = 3'h1;
      term_fn[4] = 8'h0D;
      c.set(6'h10, 6);
      `CHK("ai_switch", 16'h0444, freq_ref_q);
      c.set(6'h00, 6);
      analog_func = 4'h1;
      ai2_type = 1'b1;
      ai2_val = 16'h3733;
      step(3);
      `CHK("ai2_cur", 16'h0500, freq_ref_q);
      `CHK("ai2_flag", 1'b1, ai2_current_q);
      analog_func = 4'hA;
      ai2_type = 1'b0;
      step(3);
      `CHK("ai_sum", 16'h5955, freq_ref_q);
      ai1_val = 16'hFFFF;
      step(3);
      `CHK("ai_sat", 16'hFFFF, freq_ref_q);
      freq_alt_sel = 1'b1;
      step(3);
      `CHK("alt_key", 16'h6666, freq_ref_q);
      freq_alt_sel = 1'b0;
      freq_src_main = 3'h2;
      term_fn[3] = 8'h20;
      term_fn[4] = 8'h21;
      c.set(6'h08, 350);
      `CHK("updn_up", 1'b1, freq_ref_q >= 3 && freq_ref_q <= 4);
      c.set(6'h10, 600);
      `CHK("updn_down", 16'h0000, freq_ref_q);
      $display("Test frequency done");
      end_sim;
   end
endmodule // tb
`default_nettype wire
